// *** hdl/lcdpsq_sequencer.sv ***
/*
 * Panel-side shutdown and power sequencer with the pixel data capture stage.
 * Assumes every input is already in the pixel-clock domain and the host keeps
 * its own timing duties (shutdown spacing, reset width, clock running).
 */
`timescale 1ns/10ps
`default_nettype none
`include "lcdpsq_map.svh"

// How it works
// - While panel reset is low the gate-high rail is forced to the gate-low level.
// - After shutdown release the image starts at the tenth falling frame-sync edge.
// - Internal power comes up no later than 164 ms after shutdown release.
// - After shutdown assert the display turns off at the second falling frame-sync edge.
// - Each colour is a six-bit level, bit zero least significant, 64 steps.
// - A pixel is an 18-bit word of red, green and blue fields side by side.
// - Colour bits are active high.
module lcdpsq_sequencer
    import lcdpsq_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic shutdownIn,
    input wire logic panel_reset_low,
    input wire logic frameSync,
    input wire logic [`LCDPSQ_COLOR_W-1:0] red_bits,
    input wire logic [`LCDPSQ_COLOR_W-1:0] green_bits,
    input wire logic [`LCDPSQ_COLOR_W-1:0] blue_bits,
    output logic displayOn_ff,
    output logic powerGood_ff,
    output logic gate_high_rail_ff,
    output logic [`LCDPSQ_PIXEL_W-1:0] pixelWord_ff
);

    localparam logic [31:0] PWR_CYC = 32'(`LCDPSQ_PWR_CYC);

    lcdpsq_state_e state_ff;
    logic shutPrev_ff;
    logic syncPrev_ff;
    logic [3:0] edgeCnt_ff;
    logic [31:0] pwrCnt_ff;
    logic [7:0] boostCnt_ff;
    logic syncFall;
    logic shutRise;
    logic shutFall;
    logic showNow;

    assign syncFall = syncPrev_ff && !frameSync;
    // A panel that was showing keeps its image through the two-frame shutdown
    // wait; one that was aborted before the image came up stays dark.
    assign showNow = (state_ff == LCDPSQ_SHOW) ||
        (state_ff == LCDPSQ_WAITOFF && displayOn_ff);
    assign shutRise = shutdownIn && !shutPrev_ff;
    assign shutFall = !shutdownIn && shutPrev_ff;

    // ****************************************
    // Edge history
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            shutPrev_ff <= 1'b1;
            syncPrev_ff <= 1'b0;
        end else if (clkEn) begin
            shutPrev_ff <= shutdownIn;
            syncPrev_ff <= frameSync;
        end
    end

    // ****************************************
    // Sequencing state machine
    // ****************************************
    // Shutdown is honoured in any state so a host that breaks the spacing
    // still ends with the display blanked rather than stuck on.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= LCDPSQ_OFF;
            edgeCnt_ff <= 4'h0;
        end else if (clkEn) begin
            unique case (state_ff)
                LCDPSQ_OFF: begin
                    edgeCnt_ff <= 4'h0;
                    if (shutFall) begin
                        state_ff <= LCDPSQ_WAITON;
                    end
                end
                LCDPSQ_PWRUP, LCDPSQ_WAITON: begin
                    if (shutRise) begin
                        state_ff <= LCDPSQ_WAITOFF;
                        edgeCnt_ff <= 4'h0;
                    end else if (syncFall) begin
                        edgeCnt_ff <= edgeCnt_ff + 4'h1;
                        if (edgeCnt_ff + 4'h1 == `LCDPSQ_ON_EDGES) begin
                            state_ff <= LCDPSQ_SHOW;
                        end
                    end
                end
                LCDPSQ_SHOW: begin
                    edgeCnt_ff <= 4'h0;
                    if (shutRise) begin
                        state_ff <= LCDPSQ_WAITOFF;
                    end
                end
                LCDPSQ_WAITOFF: begin
                    if (shutFall) begin
                        state_ff <= LCDPSQ_WAITON;
                        edgeCnt_ff <= 4'h0;
                    end else if (syncFall) begin
                        edgeCnt_ff <= edgeCnt_ff + 4'h1;
                        if (edgeCnt_ff + 4'h1 == `LCDPSQ_OFF_EDGES) begin
                            state_ff <= LCDPSQ_OFF;
                        end
                    end
                end
                default: begin
                    state_ff <= LCDPSQ_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            displayOn_ff <= 1'b0;
        end else if (clkEn) begin
            displayOn_ff <= showNow;
        end
    end

    // ****************************************
    // Internal power-good timer
    // ****************************************
    // Power is declared good within the allowed window: one frame edge
    // or the timer limit, whichever comes first.
    always_ff @(posedge clock) begin
        if (rst) begin
            pwrCnt_ff <= 32'h0;
            powerGood_ff <= 1'b0;
        end else if (clkEn) begin
            if (state_ff == LCDPSQ_OFF) begin
                pwrCnt_ff <= 32'h0;
                powerGood_ff <= 1'b0;
            end else if (!powerGood_ff) begin
                pwrCnt_ff <= pwrCnt_ff + 32'h1;
                if (syncFall || pwrCnt_ff + 32'h1 >= PWR_CYC) begin
                    powerGood_ff <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Gate-high rail boost
    // ****************************************
    // The boost only advances on clock edges, so a stopped pixel clock stalls
    // the ramp instead of corrupting it.
    always_ff @(posedge clock) begin
        if (rst) begin
            boostCnt_ff <= 8'h00;
            gate_high_rail_ff <= 1'b0;
        end else if (clkEn) begin
            if (!panel_reset_low) begin
                boostCnt_ff <= 8'h00;
                gate_high_rail_ff <= 1'b0;
            end else if (boostCnt_ff != `LCDPSQ_BOOST_CYC) begin
                boostCnt_ff <= boostCnt_ff + 8'h01;
            end else begin
                gate_high_rail_ff <= 1'b1;
            end
        end
    end

    // ****************************************
    // Pixel capture
    // ****************************************
    // Blanked pixels read as gray level zero, which is black.
    always_ff @(posedge clock) begin
        if (rst) begin
            pixelWord_ff <= 18'h00000;
        end else if (clkEn) begin
            if (showNow) begin
                pixelWord_ff <= {blue_bits, green_bits, red_bits};
            end else begin
                pixelWord_ff <= 18'h00000;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_rail_low_in_reset;
        @(posedge clock) disable iff (rst)
        (clkEn && !panel_reset_low) |=> !gate_high_rail_ff;
    endproperty
    a_rail_low_in_reset: assert property (p_rail_low_in_reset)
        else $error("Gate rail high while panel reset low.");

    property p_show_after_ten;
        @(posedge clock) disable iff (rst)
        (clkEn && state_ff == LCDPSQ_WAITON && edgeCnt_ff == 4'h9 && syncFall && !shutRise)
            |=> state_ff == LCDPSQ_SHOW;
    endproperty
    a_show_after_ten: assert property (p_show_after_ten)
        else $error("Display did not start at tenth frame edge.");

    property p_no_early_show;
        @(posedge clock) disable iff (rst)
        (state_ff == LCDPSQ_WAITON && edgeCnt_ff < 4'h9) |=> state_ff != LCDPSQ_SHOW;
    endproperty
    a_no_early_show: assert property (p_no_early_show)
        else $error("Display started before tenth frame edge.");

    property p_off_after_two;
        @(posedge clock) disable iff (rst)
        (clkEn && state_ff == LCDPSQ_WAITOFF && edgeCnt_ff == 4'h1 && syncFall && !shutFall)
            |=> state_ff == LCDPSQ_OFF ##1 !displayOn_ff;
    endproperty
    a_off_after_two: assert property (p_off_after_two)
        else $error("Display not off at second frame edge.");

    property p_power_bound;
        @(posedge clock) disable iff (rst)
        (state_ff != LCDPSQ_OFF) |-> pwrCnt_ff <= PWR_CYC;
    endproperty
    a_power_bound: assert property (p_power_bound)
        else $error("Power-good timer exceeded its limit.");

    property p_pixel_order;
        @(posedge clock) disable iff (rst)
        (clkEn && state_ff == LCDPSQ_SHOW) |=>
            pixelWord_ff == {$past(blue_bits), $past(green_bits), $past(red_bits)};
    endproperty
    a_pixel_order: assert property (p_pixel_order)
        else $error("Pixel word fields out of order.");

    property p_blank_black;
        @(posedge clock) disable iff (rst)
        (clkEn && !showNow) |=> pixelWord_ff == 18'h00000;
    endproperty
    a_blank_black: assert property (p_blank_black)
        else $error("Blanked pixel not black.");

    property p_display_tracks_state;
        @(posedge clock) disable iff (rst)
        (clkEn && state_ff == LCDPSQ_OFF) |=> !displayOn_ff;
    endproperty
    a_display_tracks_state: assert property (p_display_tracks_state)
        else $error("Display on while sequencer is off.");

    property p_show_drives_display;
        @(posedge clock) disable iff (rst)
        (clkEn && state_ff == LCDPSQ_SHOW) |=> displayOn_ff;
    endproperty
    a_show_drives_display: assert property (p_show_drives_display)
        else $error("Display off while sequencer shows the image.");

endmodule // lcdpsq_sequencer

`default_nettype wire

// *** hdl/lcdpsq_map.svh ***
/*
 * Constants for the panel power sequencer: frame-edge counts and timing figures.
 * Assumes it is included by the sequencer package and the design module.
 */
`ifndef LCDPSQ_MAP_SVH
`define LCDPSQ_MAP_SVH

// Falling frame-sync edges from shutdown release to image on.
`define LCDPSQ_ON_EDGES 4'hA
// Falling frame-sync edges from shutdown assert to display off.
`define LCDPSQ_OFF_EDGES 4'h2
// Longest time from shutdown release to internal power good, in ms.
`define LCDPSQ_PWR_MAX_MS 164
// Pixel clock rate in kHz.
`define LCDPSQ_CLK_KHZ 40000
// Cycles allowed for power to come up; longest time so round down.
`define LCDPSQ_PWR_CYC ((`LCDPSQ_PWR_MAX_MS * `LCDPSQ_CLK_KHZ))
// Cycles for the gate-high boost ramp after reset release.
`define LCDPSQ_BOOST_CYC 8'h10
// Width of one colour field and of one pixel word.
`define LCDPSQ_COLOR_W 6
`define LCDPSQ_PIXEL_W 18

`endif

// *** hdl/lcdpsq_pkg.sv ***
/*
 * Types for the panel power sequencer.
 * Assumes the map header supplies the numeric constants.
 */
`include "lcdpsq_map.svh"

package lcdpsq_pkg;

    typedef enum logic [2:0] {
        LCDPSQ_OFF = 3'h0,
        LCDPSQ_PWRUP = 3'h1,
        LCDPSQ_WAITON = 3'h2,
        LCDPSQ_SHOW = 3'h3,
        LCDPSQ_WAITOFF = 3'h4
    } lcdpsq_state_e;

    typedef logic [`LCDPSQ_COLOR_W-1:0] lcdpsq_color_t;

endpackage

// *** verification/lcdpsq_host_model.sv ***
/* Host timing model: a free-running frame sync from its own counter.
 * Assumes the pixel clock runs throughout and rst is synchronous. */
`timescale 1ns/10ps
`default_nettype none
module lcdpsq_host_model #(
    parameter int FRAME_CYC = 40
) (
    input wire logic clock,
    input wire logic rst,
    output logic frameSync_ff
);
    int cnt_ff;
    // A frame is a fixed clock count, kept short so that runs stay brief.
    always_ff @(posedge clock) begin
        if (rst || cnt_ff == FRAME_CYC - 1) begin
            cnt_ff <= 0;
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
        frameSync_ff <= (cnt_ff >= 3);
    end
endmodule // lcdpsq_host_model
`default_nettype wire

// *** verification/lcd_shutdown_power_sequencer_tb.sv ***
/* Self-checking bench for the panel power sequencer.
 * Assumes the host model supplies the frame sync. */
`timescale 1ns/10ps
`default_nettype none
`include "lcdpsq_map.svh"
module lcd_shutdown_power_sequencer_tb;
    typedef struct {int kind; int due; logic [17:0] val;} lcdpsq_note_s;
    logic clock, rst, clkEn, shutdownIn, panelResetLow, frameSync, fsPrev;
    logic [5:0] redBits, greenBits, blueBits;
    logic displayOn, powerGood, rail;
    logic [17:0] pixelWord, obs, pix;
    logic [17:0] fixed [3] = '{18'h0003F, 18'h00FC0, 18'h01000};
    string nm [4] = '{"displayOn", "powerGood", "rail", "pixelWord"};
    int bad_count = 0, num_checks = 0, cyc = 0, seed, i;
    lcdpsq_note_s notes[$];
    lcdpsq_note_s note;
    lcdpsq_sequencer dut_u (.clock(clock), .rst(rst), .clkEn(clkEn),
        .shutdownIn(shutdownIn), .panel_reset_low(panelResetLow),
        .frameSync(frameSync), .red_bits(redBits), .green_bits(greenBits),
        .blue_bits(blueBits), .displayOn_ff(displayOn), .powerGood_ff(powerGood),
        .gate_high_rail_ff(rail), .pixelWord_ff(pixelWord));
    lcdpsq_host_model host_u (.clock(clock), .rst(rst), .frameSync_ff(frameSync));
    // ********************************
    // Clock, notes and monitor
    // ********************************
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        fsPrev <= frameSync;
    end
    task automatic expect_at(input int kind, input logic [17:0] val, input int dly);
        notes.push_back('{kind, cyc + 1 + dly, val});
    endtask
    // Checks run at the falling edge so that every registered output has settled.
    always @(negedge clock) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            note = notes.pop_front();
            case (note.kind)
                0: obs = {17'h0, displayOn};
                1: obs = {17'h0, powerGood};
                2: obs = {17'h0, rail};
                default: obs = pixelWord;
            endcase
            num_checks++;
            if (obs !== note.val) begin
                bad_count++;
                $display("MISMATCH %s exp %h seen %h", nm[note.kind], note.val, obs);
            end
        end
    end
    task automatic wait_falls(input int n);
        int got;
        got = 0;
        while (got < n) begin
            @(posedge clock);
            if (fsPrev === 1'b1 && frameSync === 1'b0) got++;
        end
    endtask
    task automatic close_out();
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ********************************
    // Scenarios
    // ********************************
    initial begin
        seed = 32'h2ceb846a;
        {rst, clkEn, shutdownIn, panelResetLow} = 4'hE;
        {blueBits, greenBits, redBits} = 18'h0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        expect_at(2, 18'h0, 2);
        repeat (400) @(posedge clock);
        panelResetLow <= 1'b1;
        @(posedge clock);
        expect_at(2, 18'h0, 15);
        expect_at(2, 18'h1, 16);
        wait_falls(1);
        shutdownIn <= 1'b0;
        expect_at(1, 18'h0, 1);
        wait_falls(1);
        expect_at(1, 18'h1, 2);
        wait_falls(8);
        expect_at(0, 18'h0, 2);
        wait_falls(1);
        expect_at(0, 18'h0, 0);
        expect_at(0, 18'h1, 2);
        repeat (2) @(posedge clock);
        for (i = 0; i < 12; i++) begin
            pix = (i < 3) ? fixed[i] : 18'($random(seed));
            {blueBits, greenBits, redBits} <= pix;
            expect_at(3, pix, 1);
            @(posedge clock);
        end
        clkEn <= 1'b0;
        {blueBits, greenBits, redBits} <= ~pix;
        expect_at(3, pix, 2);
        repeat (3) @(posedge clock);
        clkEn <= 1'b1;
        wait_falls(2);
        shutdownIn <= 1'b1;
        @(posedge clock);
        expect_at(0, 18'h1, 0);
        expect_at(3, ~pix, 3);
        wait_falls(1);
        expect_at(0, 18'h1, 0);
        wait_falls(1);
        expect_at(0, 18'h1, 0);
        expect_at(0, 18'h0, 1);
        expect_at(3, 18'h0, 2);
        expect_at(1, 18'h0, 3);
        wait_falls(1);
        expect_at(2, 18'h1, 0);
        panelResetLow <= 1'b0;
        @(posedge clock);
        expect_at(2, 18'h0, 1);
        repeat (400) @(posedge clock);
        panelResetLow <= 1'b1;
        // An early shutdown must abort the start-up, then a new release counts ten frames afresh.
        wait_falls(1);
        shutdownIn <= 1'b0;
        wait_falls(3);
        shutdownIn <= 1'b1;
        wait_falls(3);
        expect_at(0, 18'h0, 2);
        shutdownIn <= 1'b0;
        wait_falls(9);
        expect_at(0, 18'h0, 2);
        wait_falls(1);
        expect_at(0, 18'h0, 0);
        expect_at(0, 18'h1, 2);
        repeat (4) @(posedge clock);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        close_out();
    end
endmodule // lcd_shutdown_power_sequencer_tb
`default_nettype wire
